// [logic/pad_sync.sv]
// two-flop pad synchroniser with falling edge detect
`timescale 1ns/10ps
module pad_sync #(parameter int W = 8) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // pad levels
  pad_sync_if.sync sif
);
  logic [W-1:0] meta;
  logic [W-1:0] lvl;
  logic [W-1:0] lvl_d;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta <= '1;
      lvl <= '1;
      lvl_d <= '1;
    end else begin
      meta <= sif.raw;
      lvl <= meta;
      lvl_d <= lvl;
    end
  end

  assign sif.level = lvl;
  assign sif.fall = lvl_d & ~lvl;
endmodule

// [logic/pad_sync_if.sv]
// pad level synchroniser carrier
`timescale 1ns/10ps
interface pad_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] fall;
  modport sync (input raw, output level, output fall);
  modport user (output raw, input level, input fall);
endinterface

// [logic/pin_mux_cfg.svh]
// constants for the port s/p/j/l pin function multiplexer
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
`define AW 6
`define DW 8
`define A_ROUTE0 6'h00
`define A_ROUTE1 6'h01
`define A_ROUTE2 6'h02
`define A_ROUTE3 6'h03
`define A_IRQCTL 6'h04
`define A_S_DATA 6'h05
`define A_S_DIR 6'h06
`define A_S_IN 6'h07
`define A_P_DATA 6'h08
`define A_P_DIR 6'h09
`define A_P_IN 6'h0A
`define A_J_DATA 6'h0B
`define A_J_DIR 6'h0C
`define A_J_IN 6'h0D
`define A_L_CTL 6'h0E
`define A_XSTAT 6'h0F
`define A_STAT 6'h10
`define A_CLR 6'h14
`define A_IEN 6'h18
`define GRP_SEL 1:0
`define GRP_BLK 5:2
`define F_CAN_PHYDIR 0
`define F_CAN_MSG 1
`define F_CAN_PHY 2
`define F_SPI0 3
`define F_UART0 4
`define F_UART1 5
`define F_I2C 7:6
`define F_TRIG 1:0
`define F_PWM3 3
`define F_PWM7 7
`define F_IC1 1
`define F_IC2 2
`define F_IC3 4:3
`define F_IRQ_EDGE 7
`define F_IRQ_EN 6
`define TRIG_AT_PP4 2'h1
`define ROUTE3_RST 8'h1E
`define OC_MASK 8'h75
`define NGRP 4
`define G_S 0
`define G_P 1
`define G_L 2
`define G_OC 3
`define EV_IRQ 2
`define SYNC_W 28
`define SL_S 7:0
`define SL_P 15:8
`define SL_J 17:16
`define SL_L 19:18
`define SL_OC 27:20
`endif

// [logic/pin_mux_pkg.sv]
// types for the port s/p/j/l pin function multiplexer
package pin_mux_pkg;
  typedef logic [7:0] data_t;
  typedef logic [2:0] pad_sel_t;
  typedef enum logic [1:0] {I2C_AT_J, I2C_AT_S, I2C_AT_T, I2C_AT_NONE} i2c_loc_e;
endpackage

// [logic/port_s_p_j_l_pin_function_mux.sv]
// pin function multiplexer for ports s, p, j and l
`timescale 1ns/10ps
`include "pin_mux_cfg.svh"
module port_s_p_j_l_pin_function_mux (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [`AW-1:0] addr_in,
  input wire logic [`DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`DW-1:0] rdata_out,
  // pads
  input wire logic [7:0] s_pad_in,
  output logic [7:0] s_pad_out,
  output logic [7:0] s_pad_oe_out,
  input wire logic [7:0] p_pad_in,
  output logic [7:0] p_pad_out,
  output logic [7:0] p_pad_oe_out,
  input wire logic [1:0] j_pad_in,
  output logic [1:0] j_pad_out,
  output logic [1:0] j_pad_oe_out,
  input wire logic [1:0] l_pad_in,
  input wire logic [7:0] oc_in,
  // cpu
  input wire logic cpu_xmask_in,
  output logic nmi_req_out,
  output logic irq_req_out,
  output logic pin_irq_out,
  output logic wake_out,
  // timer0
  input wire logic [3:0] tim0_oc_en_in,
  input wire logic [3:0] tim0_oc_in,
  input wire logic tim0_ic1_en_in,
  input wire logic [3:2] tim0_ic_alt_in,
  output logic [3:0] tim0_ic_out,
  // sent
  input wire logic sent_en_in,
  input wire logic sent_transmitter_pin_in,
  output logic sent_rx_out,
  // spi1 and spi0, bits ss, sck, mosi, miso
  input wire logic spi1_en_in,
  input wire logic [3:0] spi1_oe_in,
  input wire logic [3:0] spi1_do_in,
  output logic [3:0] spi1_di_out,
  input wire logic spi0_en_in,
  input wire logic [3:0] spi0_oe_in,
  input wire logic [3:0] spi0_do_in,
  output logic [3:0] spi0_di_out,
  // uarts
  input wire logic uart0_en_in,
  input wire logic uart0_txd_in,
  output logic uart0_rxd_out,
  input wire logic uart1_en_in,
  input wire logic uart1_txd_in,
  output logic uart1_rxd_out,
  // i2c
  input wire logic i2c_en_in,
  input wire logic i2c_scl_low_in,
  input wire logic i2c_sda_low_in,
  output logic i2c_scl_out,
  output logic i2c_sda_out,
  // can and can phy
  input wire logic can_en_in,
  input wire logic can_transmit_out_in,
  input wire logic canphy_direct_out_bit_in,
  input wire logic canphy_receive_out_in,
  output logic can_receive_in_out,
  output logic canphy_transmit_in_out,
  // pwm, channels 1, 3, 5, 7
  input wire logic [3:0] pwm0_en_in,
  input wire logic [3:0] pwm0_in,
  input wire logic [3:0] fpwm_en_in,
  input wire logic [3:0] fpwm_in,
  // adc
  input wire logic adc_trigger_alt_in,
  output logic adc_external_trigger_out,
  output logic [1:0] port_l_adc_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // registers
  pin_mux_pkg::data_t route0, route1, route2, route3, irqctl;
  pin_mux_pkg::data_t s_data, s_dir, p_data, p_dir;
  pin_mux_pkg::data_t flag [`NGRP];
  pin_mux_pkg::data_t ien [`NGRP];
  pin_mux_pkg::data_t ev [`NGRP];
  pin_mux_pkg::data_t next_rdata;
  logic [1:0] j_data, j_dir, l_adc;
  logic nmi_pin_lock;

  ////////////////////////////////////////////////////////////////////////////////
  // pad synchroniser
  pad_sync_if #(.W(`SYNC_W)) psi ();
  pad_sync #(.W(`SYNC_W)) u_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .sif(psi.sync)
  );
  assign psi.raw = {~oc_in, l_pad_in, j_pad_in, p_pad_in, s_pad_in};
  logic [7:0] s_lvl, p_lvl, oc_lvl, s_fall, p_fall;
  logic [1:0] j_lvl, l_lvl, l_fall;
  assign s_lvl = psi.level[`SL_S];
  assign p_lvl = psi.level[`SL_P];
  assign j_lvl = psi.level[`SL_J];
  assign l_lvl = psi.level[`SL_L];
  assign oc_lvl = ~psi.level[`SL_OC];
  assign s_fall = psi.fall[`SL_S];
  assign p_fall = psi.fall[`SL_P];
  assign l_fall = psi.fall[`SL_L];

  ////////////////////////////////////////////////////////////////////////////////
  // register writes
  logic ien_wr, clr_wr, stat_rd, ien_rd;
  assign ien_wr = wr_in && ({addr_in[`GRP_BLK], 2'h0} == `A_IEN);
  assign clr_wr = wr_in && ({addr_in[`GRP_BLK], 2'h0} == `A_CLR);
  assign stat_rd = {addr_in[`GRP_BLK], 2'h0} == `A_STAT;
  assign ien_rd = {addr_in[`GRP_BLK], 2'h0} == `A_IEN;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {route0, route1, route2, irqctl} <= '0;
      route3 <= `ROUTE3_RST;
      {s_data, s_dir, p_data, p_dir} <= '0;
      {j_data, j_dir, l_adc} <= '0;
    end else if (wr_in) begin
      case (addr_in)
        `A_ROUTE0: route0 <= wdata_in;
        `A_ROUTE1: route1 <= wdata_in;
        `A_ROUTE2: route2 <= wdata_in;
        `A_ROUTE3: route3 <= wdata_in;
        `A_IRQCTL: irqctl <= wdata_in;
        `A_S_DATA: s_data <= wdata_in;
        `A_S_DIR: s_dir <= wdata_in;
        `A_P_DATA: p_data <= wdata_in;
        `A_P_DIR: p_dir <= wdata_in;
        `A_J_DATA: j_data <= wdata_in[1:0];
        `A_J_DIR: j_dir <= wdata_in[1:0];
        `A_L_CTL: l_adc <= wdata_in[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // non-maskable pin lock
  logic xlock_now;
  assign xlock_now = nmi_pin_lock | ~cpu_xmask_in;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nmi_pin_lock <= 1'h0;
    end else if (!cpu_xmask_in) begin
      nmi_pin_lock <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // route decode
  logic ic1_at_ps7, can_msg, can_phy, spi0_s, u0_s, u0_j, u1_s, i2c_s, i2c_j;
  logic trig_pp4, pwm7_p, pwm3_p, irq_en, irq_edge;
  assign ic1_at_ps7 = route3[`F_IC1] & tim0_ic1_en_in;
  assign can_msg = route0[`F_CAN_MSG] & (route0[`F_CAN_PHYDIR] | can_en_in);
  assign can_phy = route0[`F_CAN_PHY];
  assign spi0_s = ~route0[`F_SPI0] & spi0_en_in;
  assign u0_s = route0[`F_UART0] & uart0_en_in;
  assign u0_j = ~route0[`F_UART0] & uart0_en_in;
  assign u1_s = route0[`F_UART1] & uart1_en_in;
  assign i2c_s = (route0[`F_I2C] == pin_mux_pkg::I2C_AT_S) & i2c_en_in;
  assign i2c_j = (route0[`F_I2C] == pin_mux_pkg::I2C_AT_J) & i2c_en_in;
  assign trig_pp4 = route1[`F_TRIG] == `TRIG_AT_PP4;
  assign pwm7_p = route2[`F_PWM7] & pwm0_en_in[3];
  assign pwm3_p = route2[`F_PWM3] & pwm0_en_in[1];
  assign irq_en = irqctl[`F_IRQ_EN];
  assign irq_edge = irqctl[`F_IRQ_EDGE];

  ////////////////////////////////////////////////////////////////////////////////
  // pad priority select, {function active, oe, out}
  pin_mux_pkg::pad_sel_t s_sel [8];
  pin_mux_pkg::pad_sel_t p_sel [8];
  pin_mux_pkg::pad_sel_t j_sel [2];
  assign s_sel[7] = tim0_oc_en_in[0] ? {2'h3, tim0_oc_in[0]} : ic1_at_ps7 ? 3'h4 :
    sent_en_in ? {2'h3, sent_transmitter_pin_in} : spi1_en_in ? {1'h1, spi1_oe_in[3], spi1_do_in[3]} :
    {1'h0, s_dir[7], s_data[7]};
  assign s_sel[6] = tim0_oc_en_in[1] ? {2'h3, tim0_oc_in[1]} :
    spi1_en_in ? {1'h1, spi1_oe_in[2], spi1_do_in[2]} : {1'h0, s_dir[6], s_data[6]};
  assign s_sel[5] = tim0_oc_en_in[2] ? {2'h3, tim0_oc_in[2]} : u1_s ? {2'h3, uart1_txd_in} :
    spi1_en_in ? {1'h1, spi1_oe_in[1], spi1_do_in[1]} : {1'h0, s_dir[5], s_data[5]};
  assign s_sel[4] = tim0_oc_en_in[3] ? {2'h3, tim0_oc_in[3]} : u1_s ? 3'h4 :
    spi1_en_in ? {1'h1, spi1_oe_in[0], spi1_do_in[0]} : {1'h0, s_dir[4], s_data[4]};
  assign s_sel[3] = xlock_now ? 3'h4 :
    can_msg ? {2'h3, route0[`F_CAN_PHYDIR] ? canphy_direct_out_bit_in : can_transmit_out_in} :
    spi0_s ? {1'h1, spi0_oe_in[3], spi0_do_in[3]} : {1'h0, s_dir[3], s_data[3]};
  assign s_sel[2] = irq_en ? 3'h4 : can_msg ? 3'h4 :
    spi0_s ? {1'h1, spi0_oe_in[2], spi0_do_in[2]} : {1'h0, s_dir[2], s_data[2]};
  assign s_sel[1] = can_phy ? 3'h4 : u0_s ? {2'h3, uart0_txd_in} : i2c_s ? {1'h1, i2c_scl_low_in, 1'h0} :
    spi0_s ? {1'h1, spi0_oe_in[1], spi0_do_in[1]} : {1'h0, s_dir[1], s_data[1]};
  assign s_sel[0] = can_phy ? {2'h3, canphy_receive_out_in} : u0_s ? 3'h4 :
    i2c_s ? {1'h1, i2c_sda_low_in, 1'h0} :
    spi0_s ? {1'h1, spi0_oe_in[0], spi0_do_in[0]} : {1'h0, s_dir[0], s_data[0]};
  assign p_sel[7] = fpwm_en_in[3] ? {2'h3, fpwm_in[3]} : {1'h0, p_dir[7], p_data[7]};
  assign p_sel[6] = fpwm_en_in[2] ? {2'h3, fpwm_in[2]} : {1'h0, p_dir[6], p_data[6]};
  assign p_sel[5] = fpwm_en_in[1] ? {2'h3, fpwm_in[1]} : {1'h0, p_dir[5], p_data[5]};
  assign p_sel[4] = trig_pp4 ? 3'h4 : fpwm_en_in[0] ? {2'h3, fpwm_in[0]} :
    {1'h0, p_dir[4], p_data[4]};
  assign p_sel[3] = pwm7_p ? {2'h3, pwm0_in[3]} : {1'h0, p_dir[3], p_data[3]};
  assign p_sel[2] = pwm0_en_in[2] ? {2'h3, pwm0_in[2]} : {1'h0, p_dir[2], p_data[2]};
  assign p_sel[1] = pwm3_p ? {2'h3, pwm0_in[1]} : {1'h0, p_dir[1], p_data[1]};
  assign p_sel[0] = pwm0_en_in[0] ? {2'h3, pwm0_in[0]} : {1'h0, p_dir[0], p_data[0]};
  assign j_sel[1] = u0_j ? {2'h3, uart0_txd_in} : i2c_j ? {1'h1, i2c_scl_low_in, 1'h0} :
    {1'h0, j_dir[1], j_data[1]};
  assign j_sel[0] = u0_j ? 3'h4 : i2c_j ? {1'h1, i2c_sda_low_in, 1'h0} : {1'h0, j_dir[0], j_data[0]};

  logic [7:0] next_s_oe, next_s_do, next_p_oe, next_p_do, s_gin, p_gin;
  logic [1:0] next_j_oe, next_j_do;
  for (genvar i = 0; i < 8; i++) begin : g_sp
    assign next_s_oe[i] = s_sel[i][1];
    assign next_s_do[i] = s_sel[i][0];
    assign s_gin[i] = ~s_sel[i][2] & ~s_dir[i];
    assign next_p_oe[i] = p_sel[i][1];
    assign next_p_do[i] = p_sel[i][0];
    assign p_gin[i] = ~p_sel[i][2] & ~p_dir[i];
  end
  for (genvar i = 0; i < 2; i++) begin : g_j
    assign next_j_oe[i] = j_sel[i][1];
    assign next_j_do[i] = j_sel[i][0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt flags, set wins over clear
  logic irq_fall;
  logic [`NGRP-1:0] grp_pend;
  assign irq_fall = irq_en & irq_edge & s_fall[2];
  assign ev[`G_S] = s_fall & s_gin;
  assign ev[`G_P] = p_fall & p_gin;
  assign ev[`G_L] = {5'h00, irq_fall, l_fall};
  assign ev[`G_OC] = oc_lvl & `OC_MASK;
  for (genvar g = 0; g < `NGRP; g++) begin : g_flag
    logic [7:0] clr;
    assign clr = (clr_wr && addr_in[`GRP_SEL] == 2'(g)) ? wdata_in : 8'h00;
    assign grp_pend[g] = |(flag[g] & ien[g]);
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        flag[g] <= 8'h00;
        ien[g] <= 8'h00;
      end else begin
        flag[g] <= (flag[g] & ~clr) | ev[g];
        if (ien_wr && addr_in[`GRP_SEL] == 2'(g)) begin
          ien[g] <= wdata_in;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next output values
  logic next_nmi, next_irq, next_pin_irq, next_wake;
  logic [3:0] next_ic;
  assign next_nmi = xlock_now & ~s_lvl[3];
  assign next_irq = irq_en & (irq_edge ? flag[`G_L][`EV_IRQ] : ~s_lvl[2]);
  assign next_pin_irq = |grp_pend;
  assign next_wake = next_pin_irq | (next_nmi & ~cpu_xmask_in);
  assign next_ic = {(route3[`F_IC3] != 2'h0) ? tim0_ic_alt_in[3] : s_lvl[4],
    route3[`F_IC2] ? tim0_ic_alt_in[2] : s_lvl[5], route3[`F_IC1] ? s_lvl[7] : s_lvl[6], s_lvl[7]};

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {s_pad_out, s_pad_oe_out, p_pad_out, p_pad_oe_out, j_pad_out, j_pad_oe_out} <= '0;
      {nmi_req_out, irq_req_out, pin_irq_out, wake_out, tim0_ic_out, sent_rx_out} <= '0;
      {spi1_di_out, spi0_di_out, uart0_rxd_out, uart1_rxd_out, i2c_scl_out, i2c_sda_out} <= '0;
      {can_receive_in_out, canphy_transmit_in_out, adc_external_trigger_out, port_l_adc_out} <= '0;
    end else begin
      {s_pad_out, s_pad_oe_out, p_pad_out, p_pad_oe_out} <= {next_s_do, next_s_oe, next_p_do, next_p_oe};
      {j_pad_out, j_pad_oe_out} <= {next_j_do, next_j_oe};
      {nmi_req_out, irq_req_out, pin_irq_out, wake_out} <= {next_nmi, next_irq, next_pin_irq, next_wake};
      tim0_ic_out <= next_ic;
      sent_rx_out <= s_lvl[7];
      spi1_di_out <= s_lvl[7:4];
      spi0_di_out <= s_lvl[3:0];
      uart0_rxd_out <= route0[`F_UART0] ? s_lvl[0] : j_lvl[0];
      uart1_rxd_out <= route0[`F_UART1] ? s_lvl[4] : 1'h1;
      i2c_scl_out <= i2c_s ? s_lvl[1] : j_lvl[1];
      i2c_sda_out <= i2c_s ? s_lvl[0] : j_lvl[0];
      can_receive_in_out <= can_msg ? s_lvl[2] : 1'h1;
      canphy_transmit_in_out <= can_phy ? s_lvl[1] : 1'h1;
      adc_external_trigger_out <= trig_pp4 ? p_lvl[4] : adc_trigger_alt_in;
      port_l_adc_out <= l_lvl & l_adc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register reads
  always_comb begin
    case (addr_in)
      `A_ROUTE0: next_rdata = route0;
      `A_ROUTE1: next_rdata = route1;
      `A_ROUTE2: next_rdata = route2;
      `A_ROUTE3: next_rdata = route3;
      `A_IRQCTL: next_rdata = irqctl;
      `A_S_DATA: next_rdata = s_data;
      `A_S_DIR: next_rdata = s_dir;
      `A_S_IN: next_rdata = s_lvl;
      `A_P_DATA: next_rdata = p_data;
      `A_P_DIR: next_rdata = p_dir;
      `A_P_IN: next_rdata = p_lvl;
      `A_J_DATA: next_rdata = {6'h00, j_data};
      `A_J_DIR: next_rdata = {6'h00, j_dir};
      `A_J_IN: next_rdata = {6'h00, j_lvl};
      `A_L_CTL: next_rdata = {4'h0, l_adc, l_lvl};
      `A_XSTAT: next_rdata = {7'h00, nmi_pin_lock};
      default: next_rdata = stat_rd ? flag[addr_in[`GRP_SEL]] : ien_rd ? ien[addr_in[`GRP_SEL]] : 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rd_in ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_nmi_pin_input;
    xlock_now |=> !s_pad_oe_out[3] && nmi_pin_lock;
  endproperty
  a_nmi_pin_input: assert property (p_nmi_pin_input) else $error("nmi pin not forced to input");

  property p_nmi_pin_hold;
    nmi_pin_lock |=> nmi_pin_lock [*8];
  endproperty
  a_nmi_pin_hold: assert property (p_nmi_pin_hold) else $error("nmi lock released");

  property p_nmi_level;
    !cpu_xmask_in && !s_lvl[3] |=> nmi_req_out;
  endproperty
  a_nmi_level: assert property (p_nmi_level) else $error("nmi level not seen");

  property p_nmi_gate;
    !nmi_pin_lock && cpu_xmask_in |=> !nmi_req_out;
  endproperty
  a_nmi_gate: assert property (p_nmi_gate) else $error("nmi active while masked");

  property p_wake_xset;
    cpu_xmask_in && grp_pend == '0 |=> !wake_out;
  endproperty
  a_wake_xset: assert property (p_wake_xset) else $error("wake with x mask set");

  property p_ic_only;
    ic1_at_ps7 && !tim0_oc_en_in[0] |=> !s_pad_oe_out[7];
  endproperty
  a_ic_only: assert property (p_ic_only) else $error("ps7 capture drives pad");

  property p_oc_ps6;
    tim0_oc_en_in[1] |=> s_pad_oe_out[6] && s_pad_out[6] == $past(tim0_oc_in[1]);
  endproperty
  a_oc_ps6: assert property (p_oc_ps6) else $error("channel 1 compare not on ps6");

  property p_can_ps3;
    !xlock_now && can_msg |=>
      s_pad_oe_out[3] && s_pad_out[3] == $past(route0[`F_CAN_PHYDIR] ? canphy_direct_out_bit_in : can_transmit_out_in);
  endproperty
  a_can_ps3: assert property (p_can_ps3) else $error("ps3 can source wrong");

  property p_sent_loop;
    $stable(s_pad_in[7]) [*4] |-> sent_rx_out == s_pad_in[7];
  endproperty
  a_sent_loop: assert property (p_sent_loop) else $error("sent return level wrong");

  property p_oc_flag;
    oc_lvl[6] |=> flag[`G_OC][6];
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("over-current flag missed");

  property p_uart0_j;
    u0_j |=> j_pad_oe_out[1] && j_pad_out[1] == $past(uart0_txd_in);
  endproperty
  a_uart0_j: assert property (p_uart0_j) else $error("uart0 not on port j");

  c_nmi_pin_lock: cover property (!nmi_pin_lock ##1 nmi_pin_lock);
  c_oc_irq: cover property (flag[`G_OC] != 8'h00 ##1 pin_irq_out);
  c_can_direct: cover property (can_msg && route0[`F_CAN_PHYDIR]);
  c_irq_edge: cover property (irq_fall ##2 irq_req_out);
endmodule

// [verif/pad_world.sv]
// pad model: block drive, outside drive and undriven wander
`timescale 1ns/10ps
module pad_world #(parameter int W = 8) (
  // clock
  input wire logic sys_clk_in,
  // block side
  input wire logic [W-1:0] pad_out_in,
  input wire logic [W-1:0] pad_oe_in,
  // outside side
  input wire logic [W-1:0] ext_in,
  input wire logic [W-1:0] ext_oe_in,
  // pad level
  output logic [W-1:0] level_out
);
  logic flip = 1'b0;
  always @(posedge sys_clk_in) flip <= ~flip;
  // released pad shows a changing level
  assign level_out = pad_oe_in & pad_out_in | ~pad_oe_in & (ext_oe_in & ext_in | ~ext_oe_in & {W{flip}});
endmodule

// [verif/port_s_p_j_l_pin_function_mux_tb.sv]
// self-checking bench for the port s/p/j/l pin function multiplexer
`timescale 1ns/10ps
`include "pin_mux_cfg.svh"
module port_s_p_j_l_pin_function_mux_tb;
  logic sys_clk_in, sys_rst_in, wr_in, rd_in, cpu_xmask_in, tim0_ic1_en_in, sent_en_in, sent_transmitter_pin_in;
  logic spi1_en_in, spi0_en_in, uart0_en_in, uart0_txd_in, uart1_en_in, uart1_txd_in, i2c_en_in, can_en_in;
  logic i2c_scl_low_in, i2c_sda_low_in, can_transmit_out_in, canphy_direct_out_bit_in, canphy_receive_out_in;
  logic adc_trigger_alt_in, nmi_req_out, irq_req_out, pin_irq_out, wake_out, sent_rx_out, can_receive_in_out;
  logic adc_external_trigger_out;
  logic [5:0] addr_in;
  logic [7:0] wdata_in, rdata_out, s_pad_in, s_pad_out, s_pad_oe_out, p_pad_in, p_pad_out, p_pad_oe_out, oc_in;
  logic [17:0] ext, ext_oe;
  logic [1:0] j_pad_in, j_pad_out, j_pad_oe_out, l_pad_in, port_l_adc_out;
  logic [3:0] tim0_oc_en_in, tim0_oc_in, tim0_ic_out, spi1_oe_in, spi1_do_in, spi0_oe_in, spi0_do_in;
  logic [3:0] pwm0_en_in, pwm0_in, fpwm_en_in, fpwm_in;
  logic [3:2] tim0_ic_alt_in;
  logic [3:0] spi1_di_out, spi0_di_out;
  logic uart0_rxd_out, uart1_rxd_out, i2c_scl_out, i2c_sda_out, canphy_transmit_in_out;
  int failures = 0, compares = 0, cycles = 0;
  ////////////////////////////////////////////////////////////
  port_s_p_j_l_pin_function_mux dut_u (.sys_clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .s_pad_in, .s_pad_out, .s_pad_oe_out, .p_pad_in, .p_pad_out, .p_pad_oe_out, .j_pad_in, .j_pad_out,
    .j_pad_oe_out, .l_pad_in, .oc_in, .cpu_xmask_in, .nmi_req_out, .irq_req_out, .pin_irq_out, .wake_out,
    .tim0_oc_en_in, .tim0_oc_in, .tim0_ic1_en_in, .tim0_ic_alt_in, .tim0_ic_out, .sent_en_in, .sent_transmitter_pin_in,
    .sent_rx_out, .spi1_en_in, .spi1_oe_in, .spi1_do_in, .spi1_di_out, .spi0_en_in, .spi0_oe_in, .spi0_do_in,
    .spi0_di_out, .uart0_en_in, .uart0_txd_in, .uart0_rxd_out, .uart1_en_in, .uart1_txd_in, .uart1_rxd_out,
    .i2c_en_in, .i2c_scl_low_in, .i2c_sda_low_in, .i2c_scl_out, .i2c_sda_out, .can_en_in, .can_transmit_out_in,
    .canphy_direct_out_bit_in, .canphy_receive_out_in, .can_receive_in_out, .canphy_transmit_in_out,
    .pwm0_en_in, .pwm0_in, .fpwm_en_in, .fpwm_in, .adc_trigger_alt_in, .adc_external_trigger_out, .port_l_adc_out);
  pad_world #(.W(18)) pads_u (.sys_clk_in, .pad_out_in({j_pad_out, p_pad_out, s_pad_out}),
    .pad_oe_in({j_pad_oe_out, p_pad_oe_out, s_pad_oe_out}), .ext_in(ext), .ext_oe_in(ext_oe),
    .level_out({j_pad_in, p_pad_in, s_pad_in}));
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {sys_rst_in, cpu_xmask_in, l_pad_in, ext, ext_oe} = '1;
    {wr_in, rd_in, tim0_ic1_en_in, sent_en_in, sent_transmitter_pin_in, spi1_en_in, spi0_en_in, uart0_en_in, uart0_txd_in,
      uart1_en_in, uart1_txd_in, i2c_en_in, can_en_in, i2c_scl_low_in, i2c_sda_low_in, can_transmit_out_in,
      canphy_direct_out_bit_in, canphy_receive_out_in, adc_trigger_alt_in, addr_in, wdata_in, oc_in} = '0;
    {tim0_oc_en_in, tim0_oc_in, tim0_ic_alt_in, spi1_oe_in, spi1_do_in, spi0_oe_in, spi0_do_in} = '0;
    {pwm0_en_in, pwm0_in, fpwm_en_in, fpwm_in} = '0;
    tk(10);
    chk(s_pad_oe_out | p_pad_oe_out | {6'h0, j_pad_oe_out}, 8'h00);
    repeat (10) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(`A_ROUTE3, `ROUTE3_RST);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    @(posedge sys_clk_in);
    tim0_ic_alt_in <= 2'h2;
    tk(4);
    chk({6'h0, tim0_ic_out[3:2]}, 8'h02);
    @(posedge sys_clk_in);
    l_pad_in <= 2'h2;
    wr(`A_L_CTL, 8'h03);
    tk(4);
    rd(`A_L_CTL, 8'h0E);
    chk({6'h0, port_l_adc_out}, 8'h02);
    $display("test registers finished");
    @(posedge sys_clk_in);
    tim0_oc_en_in <= 4'h1;
    tim0_oc_in <= 4'h1;
    sent_en_in <= 1'b1;
    spi1_en_in <= 1'b1;
    spi1_oe_in <= 4'hF;
    spi1_do_in <= 4'h5;
    tk(1);
    chk({s_pad_oe_out[7:4], s_pad_out[7:4]}, 8'hFD);
    @(posedge sys_clk_in);
    tim0_oc_en_in <= 4'h0;
    tk(4);
    chk({s_pad_oe_out[7:4], s_pad_out[7:4]}, 8'hF5);
    chk({7'h0, sent_rx_out}, 8'h00);
    @(posedge sys_clk_in);
    sent_en_in <= 1'b0;
    spi1_do_in <= 4'hD;
    tk(1);
    chk({s_pad_oe_out[7:4], s_pad_out[7:4]}, 8'hFD);
    @(posedge sys_clk_in);
    spi1_en_in <= 1'b0;
    wr(`A_S_DATA, 8'hA0);
    wr(`A_S_DIR, 8'hF0);
    tk(2);
    chk({s_pad_oe_out[7:4], s_pad_out[7:4]}, 8'hFA);
    wr(`A_S_DIR, 8'h00);
    @(posedge sys_clk_in);
    tim0_ic1_en_in <= 1'b1;
    tim0_oc_en_in <= 4'h2;
    tim0_oc_in <= 4'h2;
    ext[7] <= 1'b0;
    tk(4);
    chk({4'h0, s_pad_oe_out[7:6], s_pad_out[6], tim0_ic_out[1]}, 8'h06);
    $display("test priority finished");
    @(posedge sys_clk_in);
    can_en_in <= 1'b1;
    canphy_direct_out_bit_in <= 1'b1;
    ext[2] <= 1'b0;
    wr(`A_ROUTE0, 8'h03);
    tk(2);
    chk({6'h0, s_pad_oe_out[3], s_pad_out[3]}, 8'h03);
    wr(`A_ROUTE0, 8'h02);
    tk(4);
    chk({5'h0, s_pad_oe_out[3], s_pad_out[3], can_receive_in_out}, 8'h04);
    @(posedge sys_clk_in);
    ext[3:2] <= 2'h1;
    canphy_direct_out_bit_in <= 1'b0;
    wr(`A_ROUTE0, 8'h03);
    tk(4);
    chk({5'h0, s_pad_oe_out[3], nmi_req_out, wake_out}, 8'h04);
    @(posedge sys_clk_in);
    cpu_xmask_in <= 1'b0;
    tk(4);
    chk({5'h0, s_pad_oe_out[3], nmi_req_out, wake_out}, 8'h03);
    @(posedge sys_clk_in);
    cpu_xmask_in <= 1'b1;
    tk(2);
    chk({7'h0, s_pad_oe_out[3]}, 8'h00);
    rd(`A_XSTAT, 8'h01);
    wr(`A_ROUTE0, 8'h00);
    wr(`A_IRQCTL, 8'h40);
    @(posedge sys_clk_in);
    ext[3:2] <= 2'h2;
    tk(4);
    chk({7'h0, irq_req_out}, 8'h01);
    wr(`A_IRQCTL, 8'hC0);
    wr(6'h16, 8'hFF);
    @(posedge sys_clk_in);
    ext[2] <= 1'b1;
    tk(4);
    @(posedge sys_clk_in);
    ext[2] <= 1'b0;
    tk(4);
    @(posedge sys_clk_in);
    ext[2] <= 1'b1;
    tk(4);
    chk({7'h0, irq_req_out}, 8'h01);
    rd(6'h12, 8'h04);
    wr(6'h16, 8'h04);
    tk(2);
    chk({7'h0, irq_req_out}, 8'h00);
    $display("test interrupts finished");
    wr(`A_CLR, 8'hFF);
    @(posedge sys_clk_in);
    ext[0] <= 1'b0;
    tk(4);
    rd(`A_STAT, 8'h01);
    chk({7'h0, pin_irq_out}, 8'h00);
    wr(`A_IEN, 8'h01);
    tk(2);
    chk({6'h0, pin_irq_out, wake_out}, 8'h03);
    wr(`A_CLR, 8'h01);
    tk(2);
    chk({6'h0, pin_irq_out, wake_out}, 8'h00);
    @(posedge sys_clk_in);
    fpwm_en_in <= 4'h7;
    fpwm_in <= 4'h5;
    pwm0_en_in <= 4'hD;
    pwm0_in <= 4'hD;
    oc_in <= 8'hFF;
    tk(4);
    chk(p_pad_oe_out, 8'h75);
    chk(p_pad_out & 8'h75, 8'h55);
    rd(6'h13, 8'h75);
    wr(6'h1B, 8'h04);
    tk(2);
    chk({7'h0, pin_irq_out}, 8'h01);
    @(posedge sys_clk_in);
    oc_in <= 8'h00;
    tk(4);
    wr(6'h17, 8'hFF);
    tk(2);
    chk({7'h0, pin_irq_out}, 8'h00);
    wr(`A_ROUTE2, 8'h80);
    wr(`A_ROUTE1, 8'h01);
    @(posedge sys_clk_in);
    ext[12] <= 1'b0;
    tk(4);
    chk({4'h0, p_pad_oe_out[4:3], p_pad_out[3], adc_external_trigger_out}, 8'h06);
    @(posedge sys_clk_in);
    uart0_en_in <= 1'b1;
    ext[16] <= 1'b0;
    tk(4);
    chk({3'h0, j_pad_oe_out, j_pad_out[1], uart0_rxd_out, i2c_scl_out}, 8'h10);
    chk({spi1_di_out, spi0_di_out}, 8'h7E);
    chk({5'h0, uart1_rxd_out, i2c_sda_out, canphy_transmit_in_out}, 8'h05);
    $display("test drivers finished");
    test_done();
  end
endmodule
